// ### mix_pkg.sv
/*
  Constants for the instruction execute subset: opcode patterns, field
  positions, reset values and cycle counts.
  Assumes 12-bit instruction words and an 8-bit datapath.
*/
// Function
// (RL1) copy accumulator to file, flags untouched
// (RL2) five-bit file field, one destination bit
// (RL3) destination bit zero accumulator, one file
// (RL4) accumulator loads timer setup, flags untouched
// (RL5) literal return loads accumulator, pc, two cycles
// (RL6) rotate left through carry to destination
// (RL7) rotate right through carry to destination
// (RL8) sleep sets timeout, clears powerdown, stops oscillator
// (RL9) subtract accumulator from file, update C, DC, Z
// (RL10) carry is inverted borrow after subtract
// (RL11) swap nibbles to destination, no flags
// (RL12) xor literal into accumulator, update zero
// (RL13) xor file with accumulator to destination, zero
// (RL14) direction load for selector 5, 6, 7 only
// (RL15) rotate moves carry into vacated bit
// (RL16) all-zero word idles one cycle
package mix_pkg;
  // ==========================================================
  // field layout
  localparam int F_LSB      = 0;
  localparam int F_MSB      = 4;
  localparam int D_BIT      = 5;
  localparam int K_MSB      = 7;
  // ==========================================================
  // opcode patterns
  localparam logic [11:0] OP_IDLE     = 12'h000;
  localparam logic [11:0] OP_TMRSETUP = 12'h002;
  localparam logic [11:0] OP_SLEEP    = 12'h003;
  localparam logic [6:0]  OP_MOVE_ACCUM_TO_FILE_HI = 7'h01;   // word[11:5]
  localparam logic [5:0]  OP_SUB_HI   = 6'h02;   // word[11:6]
  localparam logic [5:0]  OP_XORF_HI  = 6'h06;
  localparam logic [5:0]  OP_RRF_HI   = 6'h0C;
  localparam logic [5:0]  OP_RLF_HI   = 6'h0D;
  localparam logic [5:0]  OP_SWAP_HI  = 6'h0E;
  localparam logic [3:0]  OP_RETL_HI  = 4'h8;    // word[11:8]
  localparam logic [3:0]  OP_XORL_HI  = 4'hF;
  localparam logic [8:0]  OP_DIR_HI   = 9'h000;  // word[11:3]
  localparam logic [2:0]  DIR_A       = 3'h5;
  localparam logic [2:0]  DIR_B       = 3'h6;
  localparam logic [2:0]  DIR_C       = 3'h7;
  // ==========================================================
  // reset values and counts
  localparam logic [7:0]  ACC_RST     = 8'h00;
  localparam logic [7:0]  TMRSET_RST  = 8'hFF;
  localparam logic [7:0]  DIR_RST     = 8'hFF;
  localparam logic [10:0] PC_RST      = 11'h7FF;
  localparam int          RET_CYCLES  = 2;
endpackage

// ### mix_exec.sv
/*
  Execute stage for a subset of the 12-bit instruction set.
  Assumes one word is presented per instruction cycle on instr_i with
  instr_valid_i; the file register array is held here; the stack head
  value is supplied from outside. While busy_o is high a word is ignored.
*/
`timescale 1ns/10ps
module mix_exec
  import mix_pkg::*;
#(
  parameter int PCW = 11
) (
  input  wire logic           ref_clk_i,
  input  wire logic           rst_i,
  input  wire logic           instr_valid_i,
  input  wire logic [11:0]    instr_i,
  input  wire logic [PCW-1:0] stack_head_i,
  input  wire logic           wake_i,
  output logic [7:0]          accum_o,
  output logic                carry_o,
  output logic                half_carry_o,
  output logic                zero_o,
  output logic                timeout_flag_o,
  output logic                powerdown_flag_o,
  output logic [7:0]          timer_setup_o,
  output logic [7:0]          dir_a_o,
  output logic [7:0]          dir_b_o,
  output logic [7:0]          dir_c_o,
  output logic [PCW-1:0]      pc_o,
  output logic                busy_o,
  output logic                osc_stop_o
);
  // ==========================================================
  // decode
  logic [7:0] file_r [32];
  wire        go        = instr_valid_i & ~busy_o & ~osc_stop_o;
  wire [4:0]  faddr     = instr_i[F_MSB:F_LSB];              // RL2
  wire        dsel      = instr_i[D_BIT];                    // RL2
  wire [7:0]  lit       = instr_i[K_MSB:0];
  wire [7:0]  fval      = file_r[faddr];
  wire        is_move_accum_to_file  = go & (instr_i[11:5] == OP_MOVE_ACCUM_TO_FILE_HI);
  wire        is_sub    = go & (instr_i[11:6] == OP_SUB_HI);
  wire        is_xorf   = go & (instr_i[11:6] == OP_XORF_HI);
  wire        is_rrf    = go & (instr_i[11:6] == OP_RRF_HI);
  wire        is_rlf    = go & (instr_i[11:6] == OP_RLF_HI);
  wire        is_swap   = go & (instr_i[11:6] == OP_SWAP_HI);
  wire        is_retl   = go & (instr_i[11:8] == OP_RETL_HI);
  wire        is_xorl   = go & (instr_i[11:8] == OP_XORL_HI);
  wire        is_tmr    = go & (instr_i == OP_TMRSETUP);
  wire        is_sleep  = go & (instr_i == OP_SLEEP);
  wire        is_dir    = go & (instr_i[11:3] == OP_DIR_HI);
  wire        is_idle   = go & (instr_i == OP_IDLE);         // RL16
  // ==========================================================
  // arithmetic
  wire [8:0]  sub_full  = {1'b0, fval} + {1'b0, ~accum_o} + 9'h001;  // RL9
  wire [4:0]  sub_half  = {1'b0, fval[3:0]} + {1'b0, ~accum_o[3:0]} + 5'h01;
  wire [7:0]  rlf_res   = {fval[6:0], carry_o};              // RL6 RL15
  wire [7:0]  rrf_res   = {carry_o, fval[7:1]};              // RL7 RL15
  wire [7:0]  swp_res   = {fval[3:0], fval[7:4]};            // RL11
  wire [7:0]  xorf_res  = fval ^ accum_o;                    // RL13
  wire [7:0]  xorl_res  = accum_o ^ lit;                     // RL12
  wire        rmw       = is_sub | is_xorf | is_rrf | is_rlf | is_swap;
  wire [7:0]  rmw_res   = is_sub  ? sub_full[7:0] :
                          is_xorf ? xorf_res :
                          is_rrf  ? rrf_res :
                          is_rlf  ? rlf_res : swp_res;
  wire        wr_acc    = rmw & ~dsel;                       // RL3
  wire        wr_file   = (rmw & dsel) | is_move_accum_to_file;           // RL3 RL1
  wire [7:0]  file_wd   = is_move_accum_to_file ? accum_o : rmw_res;

  // ==========================================================
  // file registers, no reset: contents undefined at power-up
  always_ff @(posedge ref_clk_i) begin
    if (wr_file) begin
      file_r[faddr] <= file_wd;                              // RL1 RL3
    end
  end

  // accumulator
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      accum_o <= ACC_RST;
    end else if (wr_acc) begin
      accum_o <= rmw_res;                                    // RL3
    end else if (is_retl) begin
      accum_o <= lit;                                        // RL5
    end else if (is_xorl) begin
      accum_o <= xorl_res;                                   // RL12
    end
  end

  // flags: carry only from rotate and subtract
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      carry_o      <= 1'b0;
      half_carry_o <= 1'b0;
      zero_o       <= 1'b0;
    end else begin
      if (is_sub) begin
        carry_o      <= sub_full[8];                         // RL10
        half_carry_o <= sub_half[4];                         // RL9
      end else if (is_rlf) begin
        carry_o <= fval[7];                                  // RL15
      end else if (is_rrf) begin
        carry_o <= fval[0];                                  // RL15
      end
      if (is_sub) begin
        zero_o <= (sub_full[7:0] == 8'h00);                  // RL9
      end else if (is_xorf) begin
        zero_o <= (xorf_res == 8'h00);                       // RL13
      end else if (is_xorl) begin
        zero_o <= (xorl_res == 8'h00);                       // RL12
      end
    end
  end

  // timer setup and direction registers
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      timer_setup_o <= TMRSET_RST;
      dir_a_o       <= DIR_RST;
      dir_b_o       <= DIR_RST;
      dir_c_o       <= DIR_RST;
    end else begin
      if (is_tmr) timer_setup_o <= accum_o;                  // RL4
      if (is_dir && instr_i[2:0] == DIR_A) dir_a_o <= accum_o;  // RL14
      if (is_dir && instr_i[2:0] == DIR_B) dir_b_o <= accum_o;  // RL14
      if (is_dir && instr_i[2:0] == DIR_C) dir_c_o <= accum_o;  // RL14
    end
  end

  // sleep; wake only restarts the oscillator, flags stay for software
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      timeout_flag_o   <= 1'b1;
      powerdown_flag_o <= 1'b1;
      osc_stop_o       <= 1'b0;
    end else if (is_sleep) begin
      timeout_flag_o   <= 1'b1;                              // RL8
      powerdown_flag_o <= 1'b0;                              // RL8
      osc_stop_o       <= 1'b1;                              // RL8
    end else if (wake_i) begin
      osc_stop_o <= 1'b0;
    end
  end

  // program counter; literal return spends a second dead cycle
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pc_o   <= PC_RST;
      busy_o <= 1'b0;
    end else if (is_retl) begin
      pc_o   <= stack_head_i;                                // RL5
      busy_o <= 1'b1;                                        // RL5
    end else begin
      busy_o <= 1'b0;
      if (go) pc_o <= pc_o + 1'b1;                           // RL16
    end
  end

  // ==========================================================
  // checks
  AST_MOVE_ACCUM_TO_FILE_FLAGS: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    is_move_accum_to_file |=> $stable(carry_o) && $stable(zero_o) && $stable(half_carry_o))  // RL1
    else $error("flags moved on accumulator store");
  AST_MOVE_ACCUM_TO_FILE_DATA: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    is_move_accum_to_file |=> file_r[$past(faddr)] == $past(accum_o))  // RL1
    else $error("file store mismatch");
  AST_DEST_ACC: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (is_swap && !dsel) |=> accum_o == {$past(fval[3:0]), $past(fval[7:4])})  // RL11
    else $error("swap to accumulator wrong");
  AST_TMR: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    is_tmr |=> timer_setup_o == $past(accum_o) && $stable(zero_o))  // RL4
    else $error("timer setup load wrong");
  AST_RETL: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    is_retl |=> busy_o && accum_o == $past(lit) ##1 !busy_o)  // RL5
    else $error("literal return timing wrong");
  AST_RLF_C: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    is_rlf |=> carry_o == $past(fval[7]))  // RL6
    else $error("rotate left carry wrong");
  AST_RRF_C: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (is_rrf && !dsel) |=> accum_o[7] == $past(carry_o) && carry_o == $past(fval[0]))  // RL7
    else $error("rotate right wrong");
  AST_SLEEP: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    is_sleep |=> timeout_flag_o && !powerdown_flag_o && osc_stop_o)  // RL8
    else $error("sleep entry wrong");
  AST_SUB_C: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    is_sub |=> carry_o == ($past(fval) >= $past(accum_o)))  // RL10
    else $error("subtract carry wrong");
  AST_XORL_Z: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    is_xorl |=> zero_o == (accum_o == 8'h00))  // RL12
    else $error("xor literal zero flag wrong");
  AST_DIR_BAD: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (is_dir && instr_i[2:0] < DIR_A) |=> $stable(dir_a_o) && $stable(dir_b_o)
    && $stable(dir_c_o))  // RL14
    else $error("direction load on bad selector");
  AST_IDLE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    is_idle |=> $stable(accum_o) && $stable(carry_o) && pc_o == $past(pc_o) + 1'b1)  // RL16
    else $error("idle word changed state");
  COV_SUB_NEG: cover property (@(posedge ref_clk_i) is_sub && !sub_full[8]);
  COV_RETL: cover property (@(posedge ref_clk_i) is_retl ##2 go);
  COV_SLEEP: cover property (@(posedge ref_clk_i) is_sleep ##[1:20] wake_i);
  COV_XORF_F: cover property (@(posedge ref_clk_i) is_xorf && dsel);
endmodule

// ### mix_prog_mem.sv
/*
  Program memory model: hands queued words to the execute stage.
  Assumes the bench pushes words into q shortly after a clock edge.
*/
`timescale 1ns/10ps
module mix_prog_mem (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  input  wire logic        busy_i,
  input  wire logic        osc_stop_i,
  output logic             instr_valid_o,
  output logic [11:0]      instr_o
);
  logic [11:0] q[$];
  // ==========================================
  // word stands until taken; idle bus toggles so stale words never match
  initial begin
    instr_valid_o = 1'b0;
    instr_o = 12'hA5A;
  end
  always @(posedge ref_clk_i) begin
    if (!rst_i && instr_valid_o && !busy_i && !osc_stop_i && q.size() != 0) begin
      void'(q.pop_front());
    end
    #2;
    instr_valid_o = (q.size() != 0);
    instr_o = (q.size() != 0) ? q[0] : ~instr_o;
  end
endmodule

// ### mcu_instruction_execute_subset_tb.sv
/*
  Self-checking bench for the execute subset.
  Assumes the program memory model and one 20 MHz clock.
*/
`timescale 1ns/10ps
module mcu_instruction_execute_subset_tb;
  import mix_pkg::*;
  logic        ref_clk_i, rst_i, wake_i, instr_valid_i, busy_o, osc_stop_o;
  logic [11:0] instr_i;
  logic [10:0] stack_head_i, pc_o;
  logic [7:0]  accum_o, timer_setup_o, dir_a_o, dir_b_o, dir_c_o;
  logic        carry_o, half_carry_o, zero_o, timeout_flag_o, powerdown_flag_o;
  int          n_fail = 0;
  int          checks_done = 0;
  mix_exec dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .instr_valid_i(instr_valid_i),
    .instr_i(instr_i), .stack_head_i(stack_head_i), .wake_i(wake_i), .accum_o(accum_o),
    .carry_o(carry_o), .half_carry_o(half_carry_o), .zero_o(zero_o),
    .timeout_flag_o(timeout_flag_o), .powerdown_flag_o(powerdown_flag_o),
    .timer_setup_o(timer_setup_o), .dir_a_o(dir_a_o), .dir_b_o(dir_b_o),
    .dir_c_o(dir_c_o), .pc_o(pc_o), .busy_o(busy_o), .osc_stop_o(osc_stop_o));
  mix_prog_mem pm (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .busy_i(busy_o),
    .osc_stop_i(osc_stop_o), .instr_valid_o(instr_valid_i), .instr_o(instr_i));
  // ==========================================
  // helpers: every drive lands 1 ns after a rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic chk_val(input logic [10:0] got, input logic [10:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %h %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_val({10'h0, got}, {10'h0, exp});
  endtask
  task automatic do_reset();
    pm.q.delete();
    rst_i = 1'b1;
    tick(3);
    rst_i = 1'b0;
  endtask
  // bounded wait: a program that never drains counts as a mismatch
  task automatic run(input logic [11:0] w[$]);
    int k;
    foreach (w[i]) pm.q.push_back(w[i]);
    for (k = 0; k < 40 && pm.q.size() != 0; k++) tick(1);
    chk_bit(pm.q.size() == 0, 1'b1);
  endtask
  // ==========================================
  // scenarios
  task automatic t_xor_dir();
    do_reset();
    chk_val(11'(timer_setup_o), 11'h0FF);
    chk_val(pc_o, 11'h7FF);
    run('{12'hF11, 12'h005, 12'hF33, 12'h006, 12'hF66, 12'h007, 12'h002, 12'h004,
          12'h028, 12'hFAF, 12'h1A8, 12'h188});
    chk_val(11'(dir_a_o), 11'h011);
    chk_val(11'(dir_b_o), 11'h022);
    chk_val(11'(dir_c_o), 11'h044);
    chk_val(11'(timer_setup_o), 11'h044);
    chk_val(11'(accum_o), 11'h044);
    chk_bit(zero_o, 1'b0);
    run('{12'hF44, OP_IDLE});
    chk_val(11'(accum_o), 11'h000);
    chk_bit(zero_o, 1'b1);
    chk_val(pc_o, 11'h00D);
    chk_bit(powerdown_flag_o, 1'b1);
  endtask
  task automatic t_swap();
    do_reset();
    run('{12'hF4F, 12'h03F, 12'hF4F, 12'h39F, 12'h3BF, 12'h39F});
    chk_val(11'(accum_o), 11'h04F);
    chk_bit(zero_o, 1'b1);
  endtask
  task automatic t_sub();
    do_reset();
    run('{12'hF03, 12'h021, 12'hF01, 12'h0A1, 12'h081});
    chk_val(11'(accum_o), 11'h0FF);
    chk_bit(carry_o, 1'b0);
    chk_bit(half_carry_o, 1'b0);
    run('{12'h022, 12'h082});
    chk_val(11'(accum_o), 11'h000);
    chk_bit(carry_o, 1'b1);
    chk_bit(zero_o, 1'b1);
  endtask
  task automatic t_rot();
    do_reset();
    run('{12'hFE6, 12'h023, 12'h343, 12'h323});
    chk_val(11'(accum_o), 11'h0CC);
    chk_bit(carry_o, 1'b0);
    run('{12'h383});
    chk_val(11'(accum_o), 11'h03F);
    run('{12'h343});
    chk_val(11'(accum_o), 11'h0E6);
    chk_bit(carry_o, 1'b1);
  endtask
  task automatic t_ret();
    int k;
    do_reset();
    stack_head_i = 11'h123;
    pm.q.push_back(12'h8A5);
    pm.q.push_back(12'hF0F);
    for (k = 0; k < 20 && busy_o !== 1'b1; k++) tick(1);
    chk_val(pc_o, 11'h123);
    tick(1);
    chk_val(11'(accum_o), 11'h0A5);
    tick(1);
    chk_val(11'(accum_o), 11'h0AA);
    chk_val(pc_o, 11'h124);
  endtask
  task automatic t_sleep();
    do_reset();
    run('{OP_SLEEP});
    chk_bit(timeout_flag_o, 1'b1);
    chk_bit(powerdown_flag_o, 1'b0);
    chk_bit(osc_stop_o, 1'b1);
    pm.q.push_back(12'hF55);
    tick(4);
    chk_val(pc_o, 11'h000);
    wake_i = 1'b1;
    tick(1);
    wake_i = 1'b0;
    run('{OP_IDLE});
    chk_val(11'(accum_o), 11'h055);
  endtask
  task automatic final_report();
    if (n_fail == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ==========================================
  // clock, watchdog and main sequence
  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    #100000;
    n_fail++;
    final_report();
  end
  initial begin
    wake_i = 1'b0;
    stack_head_i = 11'h000;
    t_xor_dir();
    t_swap();
    t_sub();
    t_rot();
    t_ret();
    t_sleep();
    final_report();
  end
endmodule
